// ===== include/capture_timer_cfg.svh
// Register offsets, bit positions and reset values of the capture timer
`ifndef CAPTURE_TIMER_CFG_SVH
`define CAPTURE_TIMER_CFG_SVH
`define CT_OFF_IRQ_ENABLE  4'h5
`define CT_OFF_IRQ_FLAGS   4'h6
`define CT_OFF_RUN_STATUS  4'h7
`define CT_OFF_DEBUG_CTRL  4'h8
`define CT_OFF_STAGING     4'h9
`define CT_OFF_TALLY_LO    4'ha
`define CT_OFF_TALLY_HI    4'hb
`define CT_OFF_CMPSNAP_LO  4'hc
`define CT_OFF_CMPSNAP_HI  4'hd
`define CT_BIT_WRAP        1
`define CT_BIT_SNAP        0
`define CT_BIT_RUN         0
`define CT_BIT_HALT_OVR    0
`define CT_RST8            8'h00
`define CT_RST16           16'h0000
`define CT_RST2            2'h0
`define CT_ONE16           16'h0001
`define CT_MAX16           16'hffff
`define CT_ZERO8           8'h00
`endif

// ===== include/capture_timer_pkg.sv
// Types of the capture timer
package capture_timer_pkg;
    typedef enum logic [2:0] {
        MODE_PERIODIC, MODE_TIMEOUT, MODE_ON_EVENT, MODE_FREQ,
        MODE_WIDTH, MODE_FREQ_WIDTH, MODE_ONE_SHOT, MODE_PWM_8
    } operating_mode_select_e;
    typedef enum logic [1:0] {
        FW_IDLE, FW_COUNT, FW_WAIT, FW_DONE
    } fw_phase_e;
endpackage : capture_timer_pkg

// ===== logic/capture_timer_irq_count_regs.sv
// Capture timer: flags, status, staging byte, counter and compare/snapshot
`timescale 1ns/1ps
`include "capture_timer_cfg.svh"

module capture_timer_irq_count_regs (
    input  wire logic                                   clk,
    input  wire logic                                   rst_n,
    input  wire logic                                   ce,
    input  wire logic [3:0]                             addr,
    input  wire logic [7:0]                             wdata,
    input  wire logic                                   wr,
    input  wire logic                                   rd,
    output logic      [7:0]                             rdata,
    input  wire logic                                   enable,
    input  wire capture_timer_pkg::operating_mode_select_e mode,
    input  wire logic                                   event_en,
    input  wire logic                                   edge_sel,
    input  wire logic                                   event_in,
    input  wire logic                                   debug_halt,
    output logic                                        irq,
    output logic                                        running
);
    import capture_timer_pkg::*;

    logic [1:0]  irq_enable_r;
    logic [1:0]  irq_flags_r;
    logic [1:0]  irq_flags_nxt;
    logic        halt_override_r;
    logic [7:0]  staging_r;
    logic [7:0]  staging_nxt;
    logic [15:0] tally_r;
    logic [15:0] tally_nxt;
    logic [15:0] cmp_r;
    logic [15:0] cmp_nxt;
    logic        run_r;
    logic        run_nxt;
    fw_phase_e   phase_r;
    fw_phase_e   phase_nxt;
    logic        event_prev_r;
    logic [7:0]  rdata_r;
    logic        irq_r;
    logic        snap_set;
    logic        wrap_set;

    wire logic        wr_en     = wr && addr == `CT_OFF_IRQ_ENABLE;
    wire logic        wr_flags  = wr && addr == `CT_OFF_IRQ_FLAGS;
    wire logic        wr_dbg    = wr && addr == `CT_OFF_DEBUG_CTRL;
    wire logic        wr_stage  = wr && addr == `CT_OFF_STAGING;
    wire logic        wr_lo     = wr && (addr == `CT_OFF_TALLY_LO ||
                                         addr == `CT_OFF_CMPSNAP_LO);
    wire logic        wr_tally  = wr && addr == `CT_OFF_TALLY_HI;
    wire logic        wr_cmp    = wr && addr == `CT_OFF_CMPSNAP_HI;
    wire logic        rd_tally  = rd && addr == `CT_OFF_TALLY_LO;
    wire logic        rd_cmp_lo = rd && addr == `CT_OFF_CMPSNAP_LO;
    wire logic        rd_cmp    = rd_cmp_lo ||
                                  (rd && addr == `CT_OFF_CMPSNAP_HI);
    wire logic [15:0] wr_word   = {wdata, staging_r};
    wire logic        live      = !debug_halt || halt_override_r;
    wire logic        active    = enable && live;
    wire logic        ev_pos    = event_en && event_in && !event_prev_r;
    wire logic        ev_neg    = event_en && !event_in && event_prev_r;
    wire logic        ev_sel    = edge_sel ? ev_neg : ev_pos;
    wire logic        ev_opp    = edge_sel ? ev_pos : ev_neg;
    wire logic        ev_shot   = ev_pos || (edge_sel && ev_neg);
    wire logic [15:0] tally_inc = tally_r + `CT_ONE16;
    wire logic [7:0]  period_byte = cmp_r[7:0];
    wire logic [7:0]  duty_byte   = cmp_r[15:8];
    wire logic        cap_mode  = mode == MODE_ON_EVENT ||
                                  mode == MODE_FREQ ||
                                  mode == MODE_WIDTH ||
                                  mode == MODE_FREQ_WIDTH;
    wire logic        at_top    = tally_r == cmp_r;
    wire logic        snap_clr  = (wr_flags && wdata[`CT_BIT_SNAP]) ||
                                  (rd_cmp && cap_mode);
    wire logic        wrap_clr  = wr_flags && wdata[`CT_BIT_WRAP];
    wire logic [7:0]  rd_mux    =
        addr == `CT_OFF_IRQ_ENABLE ? {6'h00, irq_enable_r} :
        addr == `CT_OFF_IRQ_FLAGS  ? {6'h00, irq_flags_r} :
        addr == `CT_OFF_RUN_STATUS ? {7'h00, run_r} :
        addr == `CT_OFF_DEBUG_CTRL ? {7'h00, halt_override_r} :
        addr == `CT_OFF_STAGING    ? staging_r :
        addr == `CT_OFF_TALLY_LO   ? tally_r[7:0] :
        addr == `CT_OFF_CMPSNAP_LO ? cmp_r[7:0] :
        addr == `CT_OFF_TALLY_HI   ? staging_r :
        addr == `CT_OFF_CMPSNAP_HI ? staging_r : `CT_ZERO8;

    assign rdata   = rdata_r;
    assign irq     = irq_r;
    assign running = run_r;

    // Counting, capture and mode behaviour
    always_comb begin
        tally_nxt = tally_r;
        cmp_nxt   = cmp_r;
        run_nxt   = run_r;
        phase_nxt = phase_r;
        snap_set  = 1'b0;
        wrap_set  = 1'b0;
        if (!enable) begin
            run_nxt   = 1'b0;
            phase_nxt = FW_IDLE;
        end else if (live) begin
            case (mode)
                MODE_PERIODIC, MODE_TIMEOUT, MODE_ONE_SHOT: begin
                    if (mode == MODE_PERIODIC) begin
                        run_nxt = 1'b1;
                    end else if (mode == MODE_TIMEOUT) begin
                        if (ev_sel) begin
                            run_nxt = 1'b1;
                        end else if (ev_opp) begin
                            run_nxt = 1'b0;
                        end
                    end else if (ev_shot && !run_r) begin
                        run_nxt = 1'b1;
                    end
                    if (run_r) begin
                        wrap_set = tally_r == `CT_MAX16;
                        if (at_top) begin
                            tally_nxt = `CT_RST16;
                            snap_set  = 1'b1;
                            if (mode == MODE_ONE_SHOT) begin
                                run_nxt = 1'b0;
                            end
                        end else begin
                            tally_nxt = tally_inc;
                        end
                    end
                end
                MODE_ON_EVENT, MODE_FREQ, MODE_WIDTH: begin
                    run_nxt   = 1'b1;
                    wrap_set  = tally_r == `CT_MAX16;
                    tally_nxt = tally_inc;
                    if (mode == MODE_WIDTH && ev_sel) begin
                        tally_nxt = `CT_RST16;
                    end
                    if ((mode == MODE_WIDTH) ? ev_opp : ev_sel) begin
                        cmp_nxt  = tally_r;
                        snap_set = 1'b1;
                    end
                    if (mode == MODE_FREQ && ev_sel) begin
                        tally_nxt = `CT_RST16;
                    end
                end
                MODE_FREQ_WIDTH: begin
                    if (run_r) begin
                        wrap_set  = tally_r == `CT_MAX16;
                        tally_nxt = tally_inc;
                    end
                    case (phase_r)
                        FW_IDLE: if (ev_sel) begin
                            tally_nxt = `CT_RST16;
                            run_nxt   = 1'b1;
                            phase_nxt = FW_COUNT;
                        end
                        FW_COUNT: if (ev_opp) begin
                            cmp_nxt   = tally_r;
                            phase_nxt = FW_WAIT;
                        end
                        FW_WAIT: if (ev_sel) begin
                            tally_nxt = tally_r;
                            run_nxt   = 1'b0;
                            snap_set  = 1'b1;
                            phase_nxt = FW_DONE;
                        end
                        FW_DONE: if (!irq_flags_r[`CT_BIT_SNAP]) begin
                            phase_nxt = FW_IDLE;
                        end
                        default: phase_nxt = FW_IDLE;
                    endcase
                end
                MODE_PWM_8: begin
                    run_nxt = 1'b1;
                    if (tally_r[7:0] == period_byte) begin
                        tally_nxt = `CT_RST16;
                        wrap_set  = 1'b1;
                    end else begin
                        tally_nxt = tally_inc;
                    end
                    snap_set = tally_r[7:0] == duty_byte;
                end
                default: run_nxt = 1'b0;
            endcase
        end
        if (wr_tally) begin
            tally_nxt = wr_word;
        end
        if (wr_cmp) begin
            cmp_nxt = wr_word;
        end
    end

    // Set wins over clear for both flags
    always_comb begin
        irq_flags_nxt[`CT_BIT_SNAP] = snap_set ||
            (irq_flags_r[`CT_BIT_SNAP] && !snap_clr);
        irq_flags_nxt[`CT_BIT_WRAP] = wrap_set ||
            (irq_flags_r[`CT_BIT_WRAP] && !wrap_clr);
    end

    // Staging byte: direct write, low-byte write, low-byte read
    always_comb begin
        staging_nxt = staging_r;
        if (wr_stage || wr_lo) begin
            staging_nxt = wdata;
        end else if (rd_tally) begin
            staging_nxt = tally_r[15:8];
        end else if (rd_cmp_lo) begin
            staging_nxt = cmp_r[15:8];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_enable_r    <= `CT_RST2;
            irq_flags_r     <= `CT_RST2;
            halt_override_r <= 1'b0;
            staging_r       <= `CT_RST8;
            tally_r         <= `CT_RST16;
            cmp_r           <= `CT_RST16;
            run_r           <= 1'b0;
            phase_r         <= FW_IDLE;
            event_prev_r    <= 1'b0;
            rdata_r         <= `CT_RST8;
            irq_r           <= 1'b0;
        end else if (ce) begin
            if (wr_en) begin
                irq_enable_r <= wdata[1:0];
            end
            if (wr_dbg) begin
                halt_override_r <= wdata[`CT_BIT_HALT_OVR];
            end
            irq_flags_r  <= irq_flags_nxt;
            staging_r    <= staging_nxt;
            tally_r      <= tally_nxt;
            cmp_r        <= cmp_nxt;
            run_r        <= run_nxt;
            phase_r      <= phase_nxt;
            event_prev_r <= event_in;
            if (rd) begin
                rdata_r <= rd_mux;
            end
            irq_r <= |(irq_flags_r & irq_enable_r);
        end
    end

    AST_WRAP_SET: assert property (@(posedge clk) disable iff (!rst_n)
        ce && wrap_set |=> irq_flags_r[`CT_BIT_WRAP])
        else $error("wrap flag not set after wrap");
    AST_WRAP_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        ce && wrap_clr && !wrap_set |=> !irq_flags_r[`CT_BIT_WRAP])
        else $error("wrap flag not cleared by write of one");
    AST_TOP_MATCH: assert property (@(posedge clk) disable iff (!rst_n)
        ce && active && run_r && mode == MODE_PERIODIC && at_top && !wr_tally
        |=> irq_flags_r[`CT_BIT_SNAP] && tally_r == `CT_RST16)
        else $error("top match did not flag and restart");
    AST_FREQ_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
        ce && active && mode == MODE_FREQ && ev_sel && !wr_cmp && !wr_tally
        |=> cmp_r == $past(tally_r) && tally_r == `CT_RST16
            && irq_flags_r[`CT_BIT_SNAP])
        else $error("frequency capture wrong");
    AST_RUN_READ: assert property (@(posedge clk) disable iff (!rst_n)
        ce && rd && addr == `CT_OFF_RUN_STATUS
        |=> rdata_r == {7'h00, $past(run_r)})
        else $error("run status read mismatch");
    AST_HALT_FREEZE: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !live && !wr_tally |=> $stable(tally_r))
        else $error("counter moved during debug halt");
    AST_BUS_PRIORITY: assert property (@(posedge clk) disable iff (!rst_n)
        ce && wr_tally |=> tally_r == {$past(wdata), $past(staging_r)})
        else $error("counter write lost to internal update");
    AST_IRQ_OUT: assert property (@(posedge clk) disable iff (!rst_n)
        ce ##1 ce |-> irq_r == |($past(irq_flags_r) & $past(irq_enable_r)))
        else $error("irq does not follow enabled flags");
    AST_SNAP_READ_CLR: assert property (@(posedge clk) disable iff (!rst_n)
        ce && rd_cmp && cap_mode && !snap_set
        |=> !irq_flags_r[`CT_BIT_SNAP])
        else $error("snapshot flag not cleared by read");
endmodule : capture_timer_irq_count_regs

// ===== bench/capture_timer_irq_count_regs_tb.sv
// Self-checking bench for the capture timer register block
`timescale 1ns/1ps
module capture_timer_irq_count_regs_tb;
    import capture_timer_pkg::*;
    logic                   clk        = 1'b0;
    logic                   rst_n      = 1'b0;
    logic                   ce         = 1'b1;
    logic [3:0]             addr       = 4'h0;
    logic [7:0]             wdata      = 8'h00;
    logic                   wr         = 1'b0;
    logic                   rd         = 1'b0;
    logic [7:0]             rdata;
    logic                   enable     = 1'b0;
    operating_mode_select_e mode       = MODE_PERIODIC;
    logic                   event_en   = 1'b0;
    logic                   edge_sel   = 1'b0;
    logic                   event_in   = 1'b0;
    logic                   debug_halt = 1'b0;
    logic                   irq;
    logic                   running;
    int                     miscompares = 0;
    int                     n_checks    = 0;
    int                     cycles      = 0;
    logic [7:0]             a;
    logic [7:0]             b;

    capture_timer_irq_count_regs dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .enable(enable), .mode(mode),
        .event_en(event_en), .edge_sel(edge_sel), .event_in(event_in),
        .debug_halt(debug_halt), .irq(irq), .running(running)
    );

    always #50 clk = ~clk;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            $display("MISMATCH timeout expected done seen hang");
            miscompares = miscompares + 1;
            report_and_stop();
        end
    end

    task automatic chk_val(input string nm, input logic [7:0] exp,
                           input logic [7:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            miscompares = miscompares + 1;
        end
    endtask : chk_val

    task automatic chk_bit(input string nm, input logic exp, input logic got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            $display("MISMATCH %s expected %b seen %b", nm, exp, got);
            miscompares = miscompares + 1;
        end
    endtask : chk_bit

    // Strobe held for one edge, then one idle edge
    task automatic wr_reg(input logic [3:0] ad, input logic [7:0] d);
        addr = ad;
        wdata = d;
        wr = 1'b1;
        @(posedge clk);
        #1 wr = 1'b0;
        @(posedge clk);
        #1;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] ad, output logic [7:0] d);
        addr = ad;
        rd = 1'b1;
        @(posedge clk);
        #1 rd = 1'b0;
        d = rdata;
        @(posedge clk);
        #1;
    endtask : rd_reg

    // Polls one step after each edge, once the outputs have settled
    task automatic wait_irq(input int lim);
        int i;
        i = 0;
        while (i < lim && irq !== 1'b1) begin
            @(posedge clk);
            #1 i++;
        end
        chk_bit("irq raised", 1'b1, irq);
    endtask : wait_irq

    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        chk_bit("irq after reset", 1'b0, irq);
        chk_bit("running after reset", 1'b0, running);
        wr_reg(4'hf, 8'hff);
        for (int i = 0; i < 16; i++) begin
            rd_reg(i[3:0], a);
            chk_val("reset or unmapped", 8'h00, a);
        end
        chk_val("mode code", 8'h06, 8'(MODE_ONE_SHOT));
        chk_val("mode code", 8'h07, 8'(MODE_PWM_8));
        wr_reg(4'h9, 8'ha5);
        rd_reg(4'h9, a);
        chk_val("staging", 8'ha5, a);
        wr_reg(4'h7, 8'hff);
        rd_reg(4'h7, a);
        chk_val("run status", 8'h00, a);
        wr_reg(4'h8, 8'h01);
        rd_reg(4'h8, a);
        chk_val("debug control", 8'h01, a);
        wr_reg(4'h8, 8'h00);
        wr_reg(4'h5, 8'h03);
        rd_reg(4'h5, a);
        chk_val("irq enable", 8'h03, a);
        // Paired write, then low byte alone touches staging only
        wr_reg(4'hc, 8'h34);
        wr_reg(4'hd, 8'h12);
        wr_reg(4'hc, 8'h77);
        rd_reg(4'hc, a);
        chk_val("compare low", 8'h34, a);
        rd_reg(4'hd, a);
        chk_val("compare high", 8'h12, a);
        // Periodic mode, top 0x0010
        wr_reg(4'hc, 8'h10);
        wr_reg(4'hd, 8'h00);
        enable = 1'b1;
        wait_irq(80);
        chk_bit("running", 1'b1, running);
        rd_reg(4'h7, a);
        chk_val("run status", 8'h01, a);
        rd_reg(4'h6, a);
        chk_bit("snapshot flag", 1'b1, a[0]);
        enable = 1'b0;
        wr_reg(4'h6, 8'h03);
        rd_reg(4'h6, a);
        chk_bit("snapshot flag cleared", 1'b0, a[0]);
        chk_bit("irq dropped", 1'b0, irq);
        // Wrap from 0xffff in event mode
        mode = MODE_ON_EVENT;
        wr_reg(4'h5, 8'h02);
        wr_reg(4'ha, 8'hf0);
        wr_reg(4'hb, 8'hff);
        enable = 1'b1;
        wait_irq(60);
        rd_reg(4'h6, a);
        chk_bit("wrap flag", 1'b1, a[1]);
        chk_bit("no snapshot", 1'b0, a[0]);
        wr_reg(4'h6, 8'h00);
        rd_reg(4'h6, a);
        chk_bit("wrap flag kept", 1'b1, a[1]);
        wr_reg(4'h6, 8'h02);
        rd_reg(4'h6, a);
        chk_bit("wrap flag cleared", 1'b0, a[1]);
        chk_bit("irq dropped", 1'b0, irq);
        // Bus write while counting
        wr_reg(4'ha, 8'h00);
        wr_reg(4'hb, 8'h80);
        rd_reg(4'ha, a);
        rd_reg(4'hb, a);
        chk_val("counter high", 8'h80, a);
        // Capture on positive event edge
        wr_reg(4'h5, 8'h01);
        event_en = 1'b1;
        event_in = 1'b1;
        wait_irq(10);
        rd_reg(4'hc, a);
        rd_reg(4'hd, a);
        chk_val("captured high", 8'h80, a);
        rd_reg(4'h6, a);
        chk_bit("flag cleared by read", 1'b0, a[0]);
        event_in = 1'b0;
        // Break debug halt, then override
        debug_halt = 1'b1;
        rd_reg(4'ha, a);
        rd_reg(4'ha, b);
        chk_val("halted counter", a, b);
        wr_reg(4'h8, 8'h01);
        rd_reg(4'ha, a);
        rd_reg(4'ha, b);
        chk_bit("counter moves", 1'b1, a !== b);
        debug_halt = 1'b0;
        // Frequency mode restarts on edge
        mode = MODE_FREQ;
        event_in = 1'b1;
        @(posedge clk);
        #1;
        rd_reg(4'h6, a);
        chk_bit("freq flag", 1'b1, a[0]);
        rd_reg(4'ha, a);
        rd_reg(4'hb, a);
        chk_val("restarted high", 8'h00, a);
        rd_reg(4'hc, a);
        rd_reg(4'hd, a);
        chk_val("freq capture high", 8'h80, a);
        // Eight-bit PWM: period 0x08, duty 0x03
        enable = 1'b0;
        wr_reg(4'hc, 8'h08);
        wr_reg(4'hd, 8'h03);
        wr_reg(4'ha, 8'h00);
        wr_reg(4'hb, 8'h00);
        wr_reg(4'h6, 8'h03);
        wr_reg(4'h5, 8'h03);
        mode = MODE_PWM_8;
        enable = 1'b1;
        wait_irq(20);
        repeat (10) @(posedge clk);
        #1;
        rd_reg(4'h6, a);
        chk_val("pwm flags", 8'h03, a);
        rd_reg(4'ha, a);
        chk_bit("pwm counter in period", 1'b1, a <= 8'h08);
        // Pulse width: positive edge restarts, negative captures
        enable = 1'b0;
        event_in = 1'b0;
        mode = MODE_WIDTH;
        wr_reg(4'h6, 8'h03);
        enable = 1'b1;
        event_in = 1'b1;
        repeat (5) @(posedge clk);
        #1 event_in = 1'b0;
        wait_irq(10);
        rd_reg(4'hc, a);
        chk_val("width capture low", 8'h04, a);
        rd_reg(4'hd, a);
        chk_val("width capture high", 8'h00, a);
        // Frequency and width: restart, capture, stop on second positive edge
        enable = 1'b0;
        event_in = 1'b0;
        mode = MODE_FREQ_WIDTH;
        wr_reg(4'h6, 8'h03);
        enable = 1'b1;
        event_in = 1'b1;
        repeat (3) @(posedge clk);
        #1 event_in = 1'b0;
        repeat (2) @(posedge clk);
        #1 event_in = 1'b1;
        wait_irq(10);
        chk_bit("freq width stopped", 1'b0, running);
        rd_reg(4'hc, a);
        chk_val("width part", 8'h02, a);
        rd_reg(4'ha, a);
        rd_reg(4'ha, b);
        chk_val("stopped counter", 8'h04, a);
        chk_val("stopped counter again", 8'h04, b);
        // Single shot up to top 0x0005
        enable = 1'b0;
        event_in = 1'b0;
        mode = MODE_ONE_SHOT;
        wr_reg(4'hc, 8'h05);
        wr_reg(4'hd, 8'h00);
        wr_reg(4'ha, 8'h00);
        wr_reg(4'hb, 8'h00);
        wr_reg(4'h6, 8'h03);
        enable = 1'b1;
        repeat (3) @(posedge clk);
        #1 chk_bit("one-shot idle", 1'b0, running);
        event_in = 1'b1;
        wait_irq(20);
        chk_bit("one-shot stopped", 1'b0, running);
        rd_reg(4'ha, a);
        chk_val("one-shot counter", 8'h00, a);
        // Time-out check: negative edge starts, positive stops
        enable = 1'b0;
        mode = MODE_TIMEOUT;
        edge_sel = 1'b1;
        wr_reg(4'h6, 8'h03);
        enable = 1'b1;
        event_in = 1'b0;
        wait_irq(20);
        chk_bit("timeout running", 1'b1, running);
        event_in = 1'b1;
        repeat (2) @(posedge clk);
        #1 chk_bit("timeout stopped", 1'b0, running);
        report_and_stop();
    end
endmodule : capture_timer_irq_count_regs_tb
